// >>> design/dbh_defs.svh
// constants for the dma bus handover block
`ifndef DBH_DEFS_SVH
`define DBH_DEFS_SVH
`define DBH_REG_ADDR_LO 4'h0
`define DBH_REG_ADDR_HI 4'h1
`define DBH_REG_CNT_LO 4'h2
`define DBH_REG_CNT_HI 4'h3
`define DBH_REG_MODE 4'h8
`define DBH_REG_STATUS 4'h9
`define DBH_MODE_BLOCK 0
`define DBH_MODE_TO_MEM 1
`define DBH_MODE_ARM 2
`define DBH_MODE_RST 8'h00
`define DBH_DATA_W 8
`define DBH_FIFO_DEPTH 8
`define DBH_PIN_W 19
`define DBH_PIN_RST 19'h7b000
`define DBH_RD_SETTLE 2'h3
`define DBH_CNT_ZERO 16'h0000
`define DBH_CNT_ONE 16'h0001
`define DBH_BYTE_ZERO 8'h00
`endif

// >>> design/dbh_fifo.sv
// first-word-fall-through fifo between read and write phases
`timescale 1ns/1ps
module dbh_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] fill_q;
  logic push;
  logic pop;
  assign in_ready_o = (fill_q != (AW+1)'(D));
  assign out_valid_o = (fill_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o && en_i;
  assign pop = out_ready_i && out_valid_o && en_i;
  // storage has no reset, only pointers do
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
  // pointers wrap because depth is a power of two
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      fill_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + AW'(1);
      if (pop)
        rd_q <= rd_q + AW'(1);
      if (push && !pop)
        fill_q <= fill_q + (AW+1)'(1);
      else if (pop && !push)
        fill_q <= fill_q - (AW+1)'(1);
    end
  end
endmodule

// >>> design/dbh_pkg.sv
// types shared by the dma bus handover block
package dbh_pkg;
  typedef logic [7:0] dbh_byte_type;
  typedef logic [3:0] dbh_regaddr_type;
  // gray steps along the single-byte path from idle to drop
  typedef enum logic [3:0] {
    DBH_IDLE = 4'h0,
    DBH_REQ = 4'h1,
    DBH_OWN = 4'h3,
    DBH_ADDR = 4'h2,
    DBH_READ = 4'h6,
    DBH_WRITE = 4'h7,
    DBH_NEXT = 4'h5,
    DBH_RELEASE = 4'h4,
    DBH_DROP = 4'hc
  } dbh_state_type;
endpackage

// >>> design/dbh_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module dbh_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end
    else if (en_i)
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// >>> design/dbh_top.sv
// single channel dma engine with processor bus handover
`timescale 1ns/1ps
`include "dbh_defs.svh"
module dbh_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic chip_select_n_i,
  input wire dbh_pkg::dbh_regaddr_type reg_addr_i,
  input wire logic io_read_strobe_n_i,
  input wire logic io_write_strobe_n_i,
  input wire logic bus_ack_n_i,
  input wire logic dma_request_i,
  input wire logic ready_i,
  input wire logic end_of_process_i,
  input wire dbh_pkg::dbh_byte_type data_i,
  output logic bus_request_n_o,
  output logic dma_addr_enable_o,
  output logic latch_oe_n_o,
  output logic dma_acknowledge_n_o,
  output logic dma_upper_addr_strobe_o,
  output dbh_pkg::dbh_byte_type addr_lo_o,
  output dbh_pkg::dbh_byte_type data_o,
  output logic data_oe_n_o,
  output logic ctrl_oe_n_o,
  output logic mem_read_n_o,
  output logic mem_write_n_o,
  output logic io_read_strobe_n_o,
  output logic io_write_strobe_n_o,
  output logic end_of_process_o,
  output logic end_of_process_oe_n_o
);
  import dbh_pkg::*;

  logic [1:0] rst_q;
  logic rst_n;
  logic [`DBH_PIN_W-1:0] pins_s;
  logic cs_n_s, ior_n_s, iow_n_s, back_n_s, drq_s, ready_s, eop_n_s;
  dbh_regaddr_type ra_s;
  dbh_byte_type din_s;
  logic iow_prev_q, cs_prev_q;
  dbh_state_type state_q, state_d;
  logic [15:0] addr_q, cnt_q, addr_nx;
  logic [7:0] mode_q;
  logic tc_q, ext_q;
  logic [1:0] age_q;
  logic wr_ev, last, ext_eop, fin_ok, fo_valid, fo_ready, fi_ready;
  dbh_byte_type fo_data;

  // reset from the processor, released through two flops
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];
  // no interrupt output: the processor's one interrupt comes from the peripheral

  // every pin input is synchronised, ready included
  dbh_sync #(.W(`DBH_PIN_W), .RST_VAL(`DBH_PIN_RST)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .en_i(clk_en_i),
    .d_i({chip_select_n_i, io_read_strobe_n_i, io_write_strobe_n_i, bus_ack_n_i,
          dma_request_i, ready_i, end_of_process_i, reg_addr_i, data_i}),
    .q_o(pins_s)
  );
  assign {cs_n_s, ior_n_s, iow_n_s, back_n_s, drq_s, ready_s, eop_n_s, ra_s, din_s} = pins_s;

  // only channel request in use; no other bus requester exists
  assign last = (cnt_q == `DBH_CNT_ONE);
  // address of the coming byte, so a page crossing never latches a stale upper byte
  assign addr_nx = (state_q == DBH_NEXT) ? addr_q + `DBH_CNT_ONE : addr_q;
  // own eop drive is ignored as an external termination
  assign ext_eop = !eop_n_s && end_of_process_oe_n_o;
  // register writes end on the rising edge of the write strobe
  assign wr_ev = iow_n_s && !iow_prev_q && !cs_prev_q && (state_q == DBH_IDLE);
  // push once the read strobe has settled and ready is high
  assign fin_ok = (state_q == DBH_READ) && ready_s && (age_q == `DBH_RD_SETTLE);
  assign fo_ready = (state_q == DBH_WRITE) && ready_s && (age_q == `DBH_RD_SETTLE);

  dbh_fifo #(.W(`DBH_DATA_W), .D(`DBH_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .en_i(clk_en_i),
    .in_valid_i(fin_ok),
    .in_ready_o(fi_ready),
    .in_data_i(din_s),
    .out_valid_o(fo_valid),
    .out_ready_i(fo_ready),
    .out_data_o(fo_data)
  );

  // next state of the handover and transfer sequence
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DBH_IDLE:
        if (mode_q[`DBH_MODE_ARM] && drq_s && cnt_q != `DBH_CNT_ZERO)
          state_d = DBH_REQ;
      DBH_REQ:
        if (!back_n_s)
          state_d = DBH_OWN;
      DBH_OWN:
        state_d = DBH_ADDR;
      DBH_ADDR:
        if (ext_eop)
          state_d = DBH_RELEASE;
        else if (fi_ready) // fifo back-pressure holds the read
          state_d = DBH_READ;
      DBH_READ:
        if (ext_eop)
          state_d = DBH_RELEASE;
        else if (fin_ok)
          state_d = DBH_WRITE;
      DBH_WRITE:
        if (ext_eop)
          state_d = DBH_RELEASE;
        else if (fo_ready && fo_valid)
          state_d = DBH_NEXT;
      DBH_NEXT:
        if (last || ext_eop || !mode_q[`DBH_MODE_BLOCK])
          state_d = DBH_RELEASE;
        else
          state_d = DBH_ADDR;
      DBH_RELEASE:
        state_d = DBH_DROP;
      DBH_DROP:
        if (back_n_s)
          state_d = DBH_IDLE;
      default:
        state_d = DBH_IDLE;
    endcase
  end

  // state register and strobe settle counter, on the one system clock, gated by clk_en_i
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= DBH_IDLE;
      age_q <= 2'h0;
      iow_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end
    else if (clk_en_i)
    begin
      state_q <= state_d;
      iow_prev_q <= iow_n_s;
      cs_prev_q <= cs_n_s;
      if (state_d != state_q)
        age_q <= 2'h0;
      else if (age_q != `DBH_RD_SETTLE)
        age_q <= age_q + 2'h1;
    end
  end

  // programmed registers and running address and count
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= `DBH_CNT_ZERO;
      cnt_q <= `DBH_CNT_ZERO;
      mode_q <= `DBH_MODE_RST;
      tc_q <= 1'b0;
      ext_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (wr_ev)
        case (ra_s)
          `DBH_REG_ADDR_LO: addr_q[7:0] <= din_s;
          `DBH_REG_ADDR_HI: addr_q[15:8] <= din_s;
          `DBH_REG_CNT_LO: cnt_q[7:0] <= din_s;
          `DBH_REG_CNT_HI: cnt_q[15:8] <= din_s;
          `DBH_REG_MODE: mode_q <= din_s;
          default: ;
        endcase
      if (state_q == DBH_NEXT)
      begin
        addr_q <= addr_q + `DBH_CNT_ONE;
        cnt_q <= cnt_q - `DBH_CNT_ONE;
      end
      // flags clear on a mode write; a same-cycle set wins
      if (wr_ev && ra_s == `DBH_REG_MODE)
      begin
        tc_q <= 1'b0;
        ext_q <= 1'b0;
      end
      if (state_q == DBH_NEXT && last)
      begin
        tc_q <= 1'b1;
        mode_q[`DBH_MODE_ARM] <= 1'b0;
      end
      if (ext_eop && state_q inside {DBH_ADDR, DBH_READ, DBH_WRITE, DBH_NEXT})
      begin
        ext_q <= 1'b1;
        mode_q[`DBH_MODE_ARM] <= 1'b0;
      end
    end
  end

  // pin outputs, all registered; end of process and register reads decode the current state
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_request_n_o <= 1'b1;
      dma_addr_enable_o <= 1'b0;
      latch_oe_n_o <= 1'b1;
      dma_acknowledge_n_o <= 1'b1;
      dma_upper_addr_strobe_o <= 1'b0;
      addr_lo_o <= `DBH_BYTE_ZERO;
      data_o <= `DBH_BYTE_ZERO;
      data_oe_n_o <= 1'b1;
      ctrl_oe_n_o <= 1'b1;
      mem_read_n_o <= 1'b1;
      mem_write_n_o <= 1'b1;
      io_read_strobe_n_o <= 1'b1;
      io_write_strobe_n_o <= 1'b1;
      end_of_process_o <= 1'b0;
      end_of_process_oe_n_o <= 1'b1;
    end
    else if (clk_en_i)
    begin
      // request held from asking until after enable is dropped
      bus_request_n_o <= !(state_d inside {DBH_REQ, DBH_OWN, DBH_ADDR, DBH_READ,
                                          DBH_WRITE, DBH_NEXT, DBH_RELEASE});
      dma_addr_enable_o <= state_d inside {DBH_OWN, DBH_ADDR, DBH_READ, DBH_WRITE, DBH_NEXT};
      latch_oe_n_o <= !(state_d inside {DBH_OWN, DBH_ADDR, DBH_READ, DBH_WRITE, DBH_NEXT});
      ctrl_oe_n_o <= !(state_d inside {DBH_OWN, DBH_ADDR, DBH_READ, DBH_WRITE, DBH_NEXT});
      dma_acknowledge_n_o <= !(state_d inside {DBH_OWN, DBH_ADDR, DBH_READ, DBH_WRITE, DBH_NEXT});
      dma_upper_addr_strobe_o <= (state_d == DBH_ADDR) && (state_q != DBH_ADDR);
      addr_lo_o <= addr_nx[7:0];
      // strobes follow direction; to-memory reads the peripheral
      io_read_strobe_n_o <= !(state_d == DBH_READ && mode_q[`DBH_MODE_TO_MEM]);
      mem_read_n_o <= !(state_d == DBH_READ && !mode_q[`DBH_MODE_TO_MEM]);
      mem_write_n_o <= !(state_q == DBH_WRITE && state_d == DBH_WRITE && mode_q[`DBH_MODE_TO_MEM]);
      io_write_strobe_n_o <= !(state_q == DBH_WRITE && state_d == DBH_WRITE &&
                               !mode_q[`DBH_MODE_TO_MEM]);
      // data bus carries upper address, moved byte or register read
      if (state_d == DBH_ADDR)
      begin
        data_o <= addr_nx[15:8];
        data_oe_n_o <= 1'b0;
      end
      else if (state_q == DBH_WRITE && state_d == DBH_WRITE)
      begin
        data_o <= fo_data;
        data_oe_n_o <= 1'b0;
      end
      else if (state_q == DBH_IDLE && !cs_n_s && !ior_n_s)
      begin
        case (ra_s)
          `DBH_REG_ADDR_LO: data_o <= addr_q[7:0];
          `DBH_REG_ADDR_HI: data_o <= addr_q[15:8];
          `DBH_REG_CNT_LO: data_o <= cnt_q[7:0];
          `DBH_REG_CNT_HI: data_o <= cnt_q[15:8];
          `DBH_REG_MODE: data_o <= mode_q;
          `DBH_REG_STATUS: data_o <= {5'h00, ext_q, tc_q, drq_s};
          default: data_o <= `DBH_BYTE_ZERO;
        endcase
        data_oe_n_o <= 1'b0;
      end
      else
        data_oe_n_o <= 1'b1;
      // open drain end of process: pulled low only at count end
      end_of_process_oe_n_o <= !(state_q == DBH_NEXT && last && !ext_eop);
    end
  end

  sequence release_s;
    $fell(dma_addr_enable_o) ##1 $rose(bus_request_n_o);
  endsequence

  own_after_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(dma_addr_enable_o) |-> $past(!back_n_s) && !bus_request_n_o)
    else $error("address enable rose without bus acknowledge");
  release_order_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(dma_addr_enable_o) && clk_en_i |-> !bus_request_n_o ##0 release_s)
    else $error("request dropped before address enable");
  latch_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    latch_oe_n_o == !dma_addr_enable_o &&
    (!dma_addr_enable_o || (!back_n_s && !bus_request_n_o)))
    else $error("upper latch enable not inverse of address enable");
  block_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_q == DBH_NEXT && mode_q[`DBH_MODE_BLOCK] && !last && !ext_eop && clk_en_i
    |=> !dma_acknowledge_n_o && state_q == DBH_ADDR)
    else $error("acknowledge dropped inside a block");
  wait_state_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_q == DBH_READ && !ready_s && !ext_eop && clk_en_i |=> state_q == DBH_READ)
    else $error("read ended while ready low");
  eop_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_q == DBH_NEXT && last && !ext_eop && clk_en_i
    |=> !end_of_process_oe_n_o && !end_of_process_o && tc_q)
    else $error("end of process not driven at count end");
  ext_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ext_eop && state_q inside {DBH_ADDR, DBH_READ, DBH_WRITE} && clk_en_i
    |=> state_q == DBH_RELEASE ##1 !dma_addr_enable_o)
    else $error("external end of process ignored");
  upper_strobe_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    dma_upper_addr_strobe_o |-> !data_oe_n_o && data_o == addr_q[15:8] && dma_addr_enable_o)
    else $error("upper address strobe without address on data");
endmodule

// >>> verif/dbh_host_model.sv
// host processor and peripheral model facing the dma engine
`timescale 1ns/1ps
module dbh_host_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic bus_request_n_i,
  input wire logic dma_ack_n_i,
  input wire logic io_read_n_i,
  input wire logic drq_on_i,
  input wire logic slow_i,
  output logic bus_ack_n_o,
  output logic dma_request_o,
  output logic ready_o,
  output logic [7:0] data_o
);
  logic [7:0] src_q;
  logic rd_q;
  // processor answers a request one cycle later and floats its bus
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) bus_ack_n_o <= 1'b1;
    else bus_ack_n_o <= bus_request_n_i;
  // one channel only; request drops once acknowledged, per byte in single mode
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) dma_request_o <= 1'b0;
    else dma_request_o <= drq_on_i && dma_ack_n_i;
  // ready passes one flip-flop before the engine sees it
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) ready_o <= 1'b1;
    else ready_o <= !slow_i;
  // source byte steps after each io read strobe
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      src_q <= 8'h3c;
      rd_q <= 1'b1;
    end
    else
    begin
      rd_q <= io_read_n_i;
      if (io_read_n_i && !rd_q) src_q <= src_q + 8'h01;
    end
  // released bus shows the inverse so stale data never looks valid
  assign data_o = io_read_n_i ? ~src_q : src_q;
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the dma bus handover engine
`timescale 1ns/1ps
module tb_top;
  import dbh_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cs_n = 1'b1, iord_n = 1'b1, iowr_n = 1'b1;
  logic drq_on = 1'b0, slow = 1'b0, ext_n = 1'b1;
  dbh_regaddr_type ra = 4'h0;
  dbh_byte_type wd = 8'h00, pd, d_in, rd;
  logic back_n, dma_request, rdy, eop_w;
  logic brq_n, dma_addr_enable, loe_n, dma_acknowledge_n, ustb, doe_n, coe_n;
  logic mrd_n, mwr_n, ior_n, iow_n, eop_o, eop_oe_n;
  dbh_byte_type alo, dout;
  int num_errors = 0, n_checks = 0, cyc = 0;
  int acks, wrs, eops, rdrun, rdmax, bad;
  dbh_byte_type upq, loq, wq[$];
  logic ack_p = 1'b1, wr_p = 1'b1;
  // open-drain end of process line with pull-up
  assign eop_w = ext_n && (eop_oe_n || eop_o);
  assign d_in = cs_n ? pd : wd;
  dbh_top dbh_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
    .chip_select_n_i(cs_n), .reg_addr_i(ra), .io_read_strobe_n_i(iord_n),
    .io_write_strobe_n_i(iowr_n), .bus_ack_n_i(back_n), .dma_request_i(dma_request),
    .ready_i(rdy), .end_of_process_i(eop_w), .data_i(d_in), .bus_request_n_o(brq_n),
    .dma_addr_enable_o(dma_addr_enable), .latch_oe_n_o(loe_n), .dma_acknowledge_n_o(dma_acknowledge_n),
    .dma_upper_addr_strobe_o(ustb), .addr_lo_o(alo), .data_o(dout), .data_oe_n_o(doe_n),
    .ctrl_oe_n_o(coe_n), .mem_read_n_o(mrd_n), .mem_write_n_o(mwr_n),
    .io_read_strobe_n_o(ior_n), .io_write_strobe_n_o(iow_n),
    .end_of_process_o(eop_o), .end_of_process_oe_n_o(eop_oe_n));
  dbh_host_model dbh_host_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .bus_request_n_i(brq_n), .dma_ack_n_i(dma_acknowledge_n), .io_read_n_i(ior_n),
    .drq_on_i(drq_on), .slow_i(slow), .bus_ack_n_o(back_n), .dma_request_o(dma_request),
    .ready_o(rdy), .data_o(pd));
  // one clock feeds engine and host alike
  initial forever #2 clk_i = ~clk_i;
  // bus watcher: counts events and ownership slips every cycle
  always @(posedge clk_i)
  begin
    cyc++;
    if (!dma_acknowledge_n && ack_p) acks++;
    if (!(mwr_n && iow_n) && wr_p) wq.push_back(dout);
    if (!(mwr_n && iow_n) && wr_p) wrs++;
    if (!eop_oe_n) eops++;
    rdrun = (mrd_n && ior_n) ? 0 : rdrun + 1;
    if (rdrun > rdmax) rdmax = rdrun;
    if (ustb) upq = dout;
    if (ustb) loq = alo;
    if ((dma_addr_enable && back_n) || (loe_n !== !dma_addr_enable) || (coe_n !== !dma_addr_enable) || (dma_addr_enable && brq_n)) bad++;
    ack_p = dma_acknowledge_n;
    wr_p = mwr_n && iow_n;
    // budget is more than twenty times the longest expected run
    if (cyc == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input dbh_regaddr_type a, input dbh_byte_type d);
    @(posedge clk_i);
    cs_n <= 1'b0;
    ra <= a;
    wd <= d;
    iowr_n <= 1'b0;
    cyc_n(4);
    iowr_n <= 1'b1;
    cyc_n(4);
    cs_n <= 1'b1;
    cyc_n(2);
  endtask
  task automatic rd_reg(input dbh_regaddr_type a);
    @(posedge clk_i);
    cs_n <= 1'b0;
    ra <= a;
    iord_n <= 1'b0;
    cyc_n(5);
    rd = doe_n ? 8'hxx : dout;
    iord_n <= 1'b1;
    cs_n <= 1'b1;
    cyc_n(4);
  endtask
  // program address, count and mode; counters cleared before arming
  task automatic go(input logic [15:0] a, input logic [15:0] n, input dbh_byte_type m);
    wr_reg(4'h0, a[7:0]);
    wr_reg(4'h1, a[15:8]);
    wr_reg(4'h2, n[7:0]);
    wr_reg(4'h3, n[15:8]);
    {acks, wrs, eops, rdmax, bad} = '0;
    wq.delete();
    drq_on <= 1'b1;
    wr_reg(4'h8, m);
  endtask
  // the bus counts as free after a long quiet spell of the request line
  task automatic wait_idle();
    int q;
    int k;
    q = 0;
    for (k = 0; k < 3000 && q < 24; k++)
    begin
      @(posedge clk_i);
      q = brq_n ? q + 1 : 0;
    end
    chk("idle", 16'h1, {15'h0, q == 24});
    drq_on <= 1'b0;
    cyc_n(4);
  endtask
  task automatic t_reset();
    chk("brq", 1, brq_n);
    chk("aen", 0, dma_addr_enable);
    chk("latch_oe", 1, loe_n);
    chk("eop_oe", 1, eop_oe_n);
  endtask
  task automatic t_regs();
    wr_reg(4'h0, 8'h5a);
    wr_reg(4'h1, 8'hc3);
    rd_reg(4'h0);
    chk("addr_lo", 8'h5a, rd);
    rd_reg(4'h1);
    chk("addr_hi", 8'hc3, rd);
    rd_reg(4'h4);
    chk("unmapped", 8'h00, rd);
  endtask
  task automatic t_single();
    go(16'h7e12, 16'h0002, 8'h06);
    wait_idle();
    chk("acks", 2, acks);
    chk("writes", 2, wrs);
    chk("byte0", 8'h3c, wq[0]);
    chk("byte1", 8'h3d, wq[1]);
    chk("upper", 8'h7e, upq);
    chk("lower", 8'h13, loq);
    chk("eop", 1, eops);
    chk("own", 0, bad);
    rd_reg(4'h9);
    chk("tc", 8'h02, rd & 8'h06);
  endtask
  // ready held low freezes the first byte in its read phase
  task automatic t_stall();
    slow <= 1'b1;
    go(16'h8000, 16'h0003, 8'h05);
    cyc_n(60);
    chk("frozen", 0, wrs);
    chk("stretch", 1, rdmax >= 40);
    slow <= 1'b0;
    wait_idle();
    chk("acks", 1, acks);
    chk("writes", 3, wrs);
    chk("eop", 1, eops);
    chk("own", 0, bad);
  endtask
  task automatic t_ext_eop();
    int k;
    go(16'h9000, 16'h0008, 8'h07);
    for (k = 0; k < 500 && wrs < 2; k++) @(posedge clk_i);
    ext_n <= 1'b0;
    cyc_n(6);
    ext_n <= 1'b1;
    wait_idle();
    chk("early", 1, wrs < 8);
    chk("eop", 0, eops);
    rd_reg(4'h9);
    chk("ext", 8'h04, rd & 8'h04);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    cyc_n(6);
    reset_n_i <= 1'b1;
    cyc_n(4);
    t_reset();
    t_regs();
    t_single();
    t_stall();
    t_ext_eop();
    report_and_stop();
  end
endmodule
